// >>> verilog/pcm_defines.vh
`ifndef PCM_DEFINES_VH
`define PCM_DEFINES_VH

// register byte offsets
`define PCM_OFF_DIVISOR 12'h000
`define PCM_OFF_GATE1 12'h004
`define PCM_OFF_CTRL 12'h008
`define PCM_OFF_STATUS 12'h00C

// clock divisor register fields
`define PCM_RECOVER_BIT 15
`define PCM_DOZE_HI 14
`define PCM_DOZE_LO 12
`define PCM_SLOWDOWN_BIT 11
`define PCM_DIVISOR_RST 16'h3000
`define PCM_DIVISOR_WMASK 16'hFFDF

// gate register: bits 15..11, 7..3, 1..0 implemented
`define PCM_GATE1_WMASK 16'hF8FB
`define PCM_GATE1_RST 16'h0000

// control register fields
`define PCM_CTRL_MONITOR_EN 0
`define PCM_CTRL_WATCHDOG_EN 1
`define PCM_CTRL_PLL_EN 2
`define PCM_CTRL_WMASK 16'h0007
`define PCM_CTRL_RST 16'h0000

// power-save operand
`define PCM_OP_SLEEP 1'b0
`define PCM_OP_IDLE 1'b1

// wake restart delay, cycles (2..4 allowed)
`define PCM_WAKE_CYC 3'd3

`endif

// >>> verilog/pcm_power_clock_manager.v
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pcm_defines.vh"

// Summary of operation
// - with monitor enabled, slow osc runs always except in sleep, ignoring watchdog.
// - oscillator failure raises a trap event and selects fast internal osc.
// - fallback fast osc goes through pll when pll was in use.
// - sleep and idle entered only by power-save instruction; operand picks which.
// - sleep stops system clock source, on-chip osc and code execution.
// - clock-fail monitor inactive in sleep.
// - slow osc keeps running in sleep when watchdog enabled.
// - enabled watchdog is cleared before sleep begins.
// - sleep disables system-clocked peripherals; external-clocked ones may run.
// - enabled interrupt, reset or watchdog timeout wakes sleep or idle.
// - wake from sleep resumes on clock source active at entry.
// - idle halts cpu, clears watchdog, keeps system clock and peripherals.
// - in idle slow osc runs when watchdog or monitor enabled.
// - idle wake restores cpu clock; execution resumes 2 to 4 cycles later.
// - interrupt during power-save instruction deferred until entry completes, then wakes.
// - doze keeps system clock and peripherals full rate, divides cpu clock.
// - doze enable at bit 11, ratio field bits 14:12, 1:1 to 1:128.
// - ratio code n divides cpu clock by two to the n.
// - doze enable clear forces ratio 1:1.
// - recover-on-interrupt set makes interrupt clear doze enable.
// - set gate bit stops peripheral clocks; its registers ignore writes.
// - peripheral runs only if gate clear and present; gates reset to zero.
// - gate change takes effect after one instruction cycle.
// - bits 15..11 gate timers five to one; bits 10..8 read zero.
// - low byte gates two-wire, serial2, serial1, sync2, sync1, zero, can, adc.
module pcm_power_clock_manager #(
    parameter [15:0] PRESENT_MASK = 16'hF8FB
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire power_save_instr,
    input wire power_save_operand,
    input wire irq_pending,
    input wire watchdog_timeout,
    input wire osc_fail,
    output wire cpu_clk_en,
    output wire cpu_run,
    output reg sleep_active,
    output reg idle_active,
    output reg sys_osc_en,
    output reg fast_osc_sel,
    output reg fast_osc_via_pll,
    output reg slow_osc_en,
    output reg clock_fail_trap,
    output reg watchdog_clear,
    output reg sysclk_periph_en,
    output reg [15:0] module_clock_gate
);

    localparam ST_RUN = 3'd0;
    localparam ST_ENTER = 3'd1;
    localparam ST_SLEEP = 3'd2;
    localparam ST_IDLE = 3'd3;
    localparam ST_WAKE = 3'd4;

    reg [15:0] divisor_r;
    reg [15:0] gate1_r;
    reg [15:0] ctrl_r;
    reg [2:0] state_r;
    reg mode_r;
    reg [2:0] wake_cnt_r;
    reg [6:0] doze_cnt_r;
    reg clk_fail_r;
    reg a_ph_r;
    reg a_wr_r;
    reg [11:0] a_addr_r;

    wire monitor_en = ctrl_r[`PCM_CTRL_MONITOR_EN];
    wire watchdog_en = ctrl_r[`PCM_CTRL_WATCHDOG_EN];
    wire low_power = (state_r == ST_SLEEP) || (state_r == ST_IDLE);
    wire wake_evt = irq_pending | watchdog_timeout;
    wire slowdown_en = divisor_r[`PCM_SLOWDOWN_BIT];
    wire [2:0] doze_code = divisor_r[`PCM_DOZE_HI:`PCM_DOZE_LO];
    // divider terminal count: 2**code - 1
    wire [6:0] doze_tc = slowdown_en ? ((7'd1 << doze_code) - 7'd1) : 7'd0;
    // at or past the count, so a smaller ratio takes hold at once instead of after a wrap
    wire doze_tick = (doze_cnt_r >= doze_tc);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // enable pulses only on system edges so peripheral registers stay in step
    assign cpu_run = (state_r == ST_RUN);
    assign cpu_clk_en = cpu_run & doze_tick;

    wire addr_take = hsel & hready & htrans[1];
    wire wr_divisor = a_ph_r & a_wr_r & (a_addr_r == `PCM_OFF_DIVISOR);
    wire wr_gate = a_ph_r & a_wr_r & (a_addr_r == `PCM_OFF_GATE1);
    wire wr_ctrl = a_ph_r & a_wr_r & (a_addr_r == `PCM_OFF_CTRL);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_ph_r <= 1'b0;
            a_wr_r <= 1'b0;
            a_addr_r <= 12'h000;
        end else if (hready) begin
            a_ph_r <= addr_take;
            a_wr_r <= hwrite;
            a_addr_r <= {haddr[11:2], 2'b00};
        end
    end

    always @* begin
        hrdata = 32'h0000_0000;
        if (a_ph_r && !a_wr_r) begin
            case (a_addr_r)
                `PCM_OFF_DIVISOR: hrdata = {16'h0000, divisor_r};
                `PCM_OFF_GATE1: hrdata = {16'h0000, gate1_r};
                `PCM_OFF_CTRL: hrdata = {16'h0000, ctrl_r};
                `PCM_OFF_STATUS: hrdata = {26'h000_0000, clk_fail_r, fast_osc_via_pll,
                    fast_osc_sel, idle_active, sleep_active, cpu_run};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // register file; an interrupt clearing doze wins over a same-cycle write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            divisor_r <= `PCM_DIVISOR_RST;
            gate1_r <= `PCM_GATE1_RST;
            ctrl_r <= `PCM_CTRL_RST;
        end else begin
            if (wr_divisor) begin
                divisor_r <= hwdata[15:0] & `PCM_DIVISOR_WMASK;
            end
            if (irq_pending && divisor_r[`PCM_RECOVER_BIT]) begin
                divisor_r[`PCM_SLOWDOWN_BIT] <= 1'b0;
            end
            if (wr_gate) begin
                gate1_r <= hwdata[15:0] & `PCM_GATE1_WMASK;
            end
            if (wr_ctrl) begin
                ctrl_r <= hwdata[15:0] & `PCM_CTRL_WMASK;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            doze_cnt_r <= 7'd0;
        end else if (doze_tick || !cpu_run) begin
            doze_cnt_r <= 7'd0;
        end else begin
            doze_cnt_r <= doze_cnt_r + 7'd1;
        end
    end

    // gate register drives clocks one cycle later; absent units stay gated
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_gate
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    module_clock_gate[gi] <= 1'b0;
                end else begin
                    module_clock_gate[gi] <= gate1_r[gi] | ~PRESENT_MASK[gi];
                end
            end
        end
    endgenerate

    // power-save sequencer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_RUN;
            mode_r <= `PCM_OP_SLEEP;
            wake_cnt_r <= 3'd0;
            watchdog_clear <= 1'b0;
        end else begin
            watchdog_clear <= 1'b0;
            case (state_r)
                ST_RUN: begin
                    if (power_save_instr) begin
                        mode_r <= power_save_operand;
                        watchdog_clear <= watchdog_en;
                        state_r <= ST_ENTER;
                    end
                end
                ST_ENTER: begin
                    // interrupts held off here, seen once low-power state stands
                    state_r <= (mode_r == `PCM_OP_IDLE) ? ST_IDLE : ST_SLEEP;
                end
                ST_SLEEP, ST_IDLE: begin
                    if (wake_evt) begin
                        wake_cnt_r <= `PCM_WAKE_CYC;
                        state_r <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (wake_cnt_r <= 3'd1) begin
                        state_r <= ST_RUN;
                    end else begin
                        wake_cnt_r <= wake_cnt_r - 3'd1;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_active <= 1'b0;
            idle_active <= 1'b0;
            sys_osc_en <= 1'b1;
            sysclk_periph_en <= 1'b1;
            slow_osc_en <= 1'b0;
        end else begin
            sleep_active <= (state_r == ST_SLEEP);
            idle_active <= (state_r == ST_IDLE);
            // source selection is kept, so wake resumes on the same clock
            sys_osc_en <= (state_r != ST_SLEEP);
            sysclk_periph_en <= (state_r != ST_SLEEP);
            if (state_r == ST_SLEEP) begin
                slow_osc_en <= watchdog_en;
            end else begin
                slow_osc_en <= monitor_en | watchdog_en;
            end
        end
    end

    // fail monitor; failure latch holds until reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_fail_r <= 1'b0;
            clock_fail_trap <= 1'b0;
            fast_osc_sel <= 1'b0;
            fast_osc_via_pll <= 1'b0;
        end else begin
            clock_fail_trap <= 1'b0;
            if (monitor_en && osc_fail && !clk_fail_r && state_r != ST_SLEEP) begin
                clk_fail_r <= 1'b1;
                clock_fail_trap <= 1'b1;
                fast_osc_sel <= 1'b1;
                fast_osc_via_pll <= ctrl_r[`PCM_CTRL_PLL_EN];
            end
        end
    end

endmodule // pcm_power_clock_manager

// >>> dv/pcm_checker.sv
`timescale 1ns/1ps
module pcm_checker (
    input wire hclk,
    input wire hresetn,
    input wire power_save_instr,
    input wire osc_fail,
    input wire cpu_run,
    input wire sleep_active,
    input wire idle_active,
    input wire sys_osc_en,
    input wire sysclk_periph_en,
    input wire fast_osc_sel,
    input wire clock_fail_trap,
    input wire watchdog_clear
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_run_leaves: assert property (power_save_instr && cpu_run |-> ##2 !cpu_run)
        else $error("core still running after power-save");
    // entry latency is 3 edges from the sampled instruction to the rise; a 4-edge past is also accepted
    a_entry_by_instr: assert property ($rose(sleep_active) || $rose(idle_active) |->
        $past(power_save_instr, 3) || $past(power_save_instr, 4))
        else $error("low-power state without instruction");
    a_sleep_clk_off: assert property ($rose(sleep_active) |-> !sys_osc_en && !sysclk_periph_en)
        else $error("clocks still on in sleep");
    a_idle_clk_on: assert property (idle_active |-> sys_osc_en && sysclk_periph_en && !cpu_run)
        else $error("idle clocks wrong");
    a_clear_halted: assert property (watchdog_clear |-> !cpu_run)
        else $error("watchdog cleared while running");
    a_trap_pulse: assert property (clock_fail_trap |-> fast_osc_sel ##1 !clock_fail_trap)
        else $error("trap pulse or fallback wrong");
    a_trap_cause: assert property ($rose(clock_fail_trap) |-> $past(osc_fail) && $past(sys_osc_en))
        else $error("trap without failure or in sleep");
    a_wake_bound: assert property ($fell(sleep_active) || $fell(idle_active) |-> ##[0:4] cpu_run)
        else $error("wake too slow");
endmodule // pcm_checker

// >>> dv/pcm_core.sv
`timescale 1ns/1ps
module pcm_core (
    input wire hclk,
    input wire cpu_run,
    output logic power_save_instr,
    output logic power_save_operand,
    output logic irq_pending,
    output logic watchdog_timeout,
    output logic osc_fail
);
    initial {power_save_instr, power_save_operand, irq_pending, watchdog_timeout, osc_fail} = 5'h00;
    // an interrupt may coincide with the instruction on purpose
    task automatic power_save(input logic op, input logic irq);
        do @(posedge hclk); while (cpu_run !== 1'b1);
        power_save_instr <= 1'b1;
        power_save_operand <= op;
        irq_pending <= irq;
        @(posedge hclk);
        power_save_instr <= 1'b0;
        power_save_operand <= ~op;
    endtask
    task automatic ev(input logic [2:0] v);
        @(posedge hclk);
        {irq_pending, watchdog_timeout, osc_fail} <= v;
    endtask
endmodule // pcm_core

// >>> dv/tb_pcm_power_clock_manager.sv
`timescale 1ns/1ps
module tb_pcm_power_clock_manager;
    logic hclk, hresetn, hsel, hwrite;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, q;
    wire [31:0] hrdata;
    wire [15:0] module_clock_gate;
    wire hreadyout, hresp, power_save_instr, power_save_operand, irq_pending, watchdog_timeout, osc_fail;
    wire cpu_clk_en;
    wire cpu_run, sleep_active, idle_active, sys_osc_en, fast_osc_sel, fast_osc_via_pll, slow_osc_en;
    wire clock_fail_trap, watchdog_clear, sysclk_periph_en;
    int err_count, check_count, cyc, wdc, trp;
    pcm_power_clock_manager u_pcm_power_clock_manager (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .power_save_instr,
        .power_save_operand, .irq_pending, .watchdog_timeout, .osc_fail, .cpu_clk_en, .cpu_run, .sleep_active,
        .idle_active, .sys_osc_en, .fast_osc_sel, .fast_osc_via_pll, .slow_osc_en, .clock_fail_trap,
        .watchdog_clear, .sysclk_periph_en, .module_clock_gate);
    pcm_core u_pcm_core (.hclk, .cpu_run, .power_save_instr, .power_save_operand, .irq_pending,
        .watchdog_timeout, .osc_fail);
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(q, {16'h0000, e});
    endtask
    // bit index: 0 sleep, 1 idle, 2 running, 3 fallback osc
    task automatic wt(input int s, input logic v);
        logic [3:0] b;
        for (int i = 0; i < 12; i++) begin
            b = {fast_osc_sel, cpu_run, idle_active, sleep_active};
            if (b[s] === v) break;
            @(posedge hclk);
        end
    endtask
    // 256 cycles hold a whole number of periods for every ratio, so phase does not matter
    task automatic doze(input logic [15:0] v, input int e);
        int n;
        bus(1'b1, 12'h000, v);
        repeat (2) @(posedge hclk);
        n = 0;
        repeat (256) begin
            @(posedge hclk);
            n += int'(cpu_clk_en);
        end
        chk(32'(n), 32'(e));
    endtask
    always @(posedge hclk) begin
        cyc++;
        wdc += int'(watchdog_clear);
        trp += int'(clock_fail_trap);
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        chk({sys_osc_en, sysclk_periph_en, cpu_run, sleep_active, module_clock_gate}, 32'h000E_0000);
        rd(12'h000, 16'h3000);
        bus(1'b1, 12'h004, 16'hFFFF);
        rd(12'h004, 16'hF8FB);
        repeat (3) @(posedge hclk);
        chk(32'(module_clock_gate), 32'h0000_FFFF);
        bus(1'b1, 12'h004, 16'h0000);
        repeat (3) @(posedge hclk);
        chk(32'(module_clock_gate), 32'h0000_0704);
        bus(1'b1, 12'h100, 16'hFFFF);
        rd(12'h100, 16'h0000);
        $display("gates test done");
        for (int k = 0; k < 8; k++) doze(16'h0800 | 16'(k << 12), 256 >> k);
        doze(16'h7000, 256);
        bus(1'b1, 12'h000, 16'hB800);
        u_pcm_core.ev(3'b100);
        u_pcm_core.ev(3'b000);
        rd(12'h000, 16'hB000);
        bus(1'b1, 12'h000, 16'h3800);
        u_pcm_core.ev(3'b100);
        u_pcm_core.ev(3'b000);
        rd(12'h000, 16'h3800);
        $display("doze test done");
        bus(1'b1, 12'h008, 16'h0002);
        u_pcm_core.power_save(1'b1, 1'b0);
        wt(1, 1'b1);
        chk({idle_active, sleep_active, cpu_run, sys_osc_en, sysclk_periph_en, slow_osc_en}, 32'h27);
        u_pcm_core.ev(3'b100);
        wt(2, 1'b1);
        u_pcm_core.ev(3'b000);
        chk({cpu_run, 31'(wdc)}, 32'h8000_0001);
        bus(1'b1, 12'h008, 16'h0007);
        u_pcm_core.ev(3'b001);
        wt(3, 1'b1);
        u_pcm_core.ev(3'b000);
        chk({fast_osc_via_pll, slow_osc_en, 30'(trp)}, 32'hC000_0001);
        rd(12'h00C, 16'h0039);
        $display("idle and fail test done");
        u_pcm_core.power_save(1'b0, 1'b0);
        wt(0, 1'b1);
        chk({sleep_active, idle_active, sys_osc_en, sysclk_periph_en, slow_osc_en}, 32'h11);
        u_pcm_core.ev(3'b010);
        wt(2, 1'b1);
        u_pcm_core.ev(3'b000);
        chk({fast_osc_sel, cpu_run, 30'(wdc)}, 32'hC000_0002);
        u_pcm_core.power_save(1'b0, 1'b1);
        wt(0, 1'b1);
        chk(32'(sleep_active), 32'h1);
        wt(2, 1'b1);
        u_pcm_core.ev(3'b000);
        chk(32'(cpu_run), 32'h1);
        $display("sleep test done");
        tally_and_finish();
    end
endmodule // tb_pcm_power_clock_manager
bind pcm_power_clock_manager pcm_checker u_pcm_checker (.hclk, .hresetn, .power_save_instr, .osc_fail,
    .cpu_run, .sleep_active, .idle_active, .sys_osc_en, .sysclk_periph_en, .fast_osc_sel, .clock_fail_trap,
    .watchdog_clear);
